// >>> rtl/video_oe_map.svh
// Offsets, timing counts and encodings for the output enable sequencer
`ifndef VIDEO_OE_MAP_SVH
`define VIDEO_OE_MAP_SVH

// Reference clock rate, kHz (50 MHz, 20 ns period)
`define CLK_FREQ_KHZ     32'd50000
// Shortest and longest float interval after power-on, ms
`define FLOAT_MIN_MS     32'd20
`define FLOAT_MAX_MS     32'd200
// Float interval in reference cycles, least time rounded up
`define FLOAT_CYCLES     (`FLOAT_MIN_MS * `CLK_FREQ_KHZ)
`define FLOAT_CNT_W      21
// Length of the internal synchronous reset sequence, reference cycles
`define SYNC_CYCLES      8'h20
// Pipeline latency in line-locked clocks with zero luma adjustment
`define LATENCY_LINE_CLK 8'hb3
`define MEM_DEPTH        187
// Output format code of the 8-bit serial format
`define FMT_SERIAL8      2'h3
// Clock qualifier rate choices
`define QUAL_HALF        2'h0
`define QUAL_QUARTER     2'h1
`define QUAL_EIGHTH      2'h2
// Number of toggle stages: line-locked clock and its three divisions
`define DIV_STAGES       4
// Line-locked clock is this multiple of the line-frequency oscillator
`define OSC_MULT         4
// Nominal clock family, kHz
`define LINE_CLK_NOM_KHZ    32'd27000
`define HALF_CLK_NOM_KHZ    32'd13500
`define QUARTER_CLK_NOM_KHZ 32'd6750
`define EIGHTH_CLK_NOM_KHZ  32'd3375

`endif

// >>> rtl/video_oe_pkg.sv
// Types shared by the output enable sequencer
package video_oe_pkg;

  // Sequencer states, Gray along the power-on path
  typedef enum logic [1:0] {
    ST_FLOAT  = 2'h0,
    ST_SYNC   = 2'h1,
    ST_READY  = 2'h3,
    ST_ACTIVE = 2'h2
  } seq_state_t;

  // Video port: two bytes, each with its own enable
  typedef struct packed {
    logic [7:0] hiData;
    logic [7:0] loData;
    logic       hiOe;
    logic       loOe;
  } port_bus_t;

  // Clock family and qualifier, one shared enable
  typedef struct packed {
    logic lineClk;
    logic halfClk;
    logic quarterClk;
    logic eighthClk;
    logic clkQual;
    logic oe;
  } clk_bus_t;

  // Reference and sync pins
  typedef struct packed {
    logic horizRef;
    logic horizSync;
    logic vertSync;
    logic oe;
  } sync_bus_t;

  // Real-time control, status and switch pins
  typedef struct packed {
    logic ctlOut;
    logic status0;
    logic status1;
    logic switchOut;
    logic oe;
  } rt_bus_t;

endpackage

// >>> rtl/clock_div_stage.sv
// One toggle stage of the line-locked clock divider chain
`timescale 1ns/1ns
module clock_div_stage (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic tick,      // Advance pulse from previous stage
  output logic      level,     // Square wave, even duty
  output logic      rise       // One-cycle pulse on rising step
);

  logic q_ff;                  // Toggle state

  // Toggle on every tick, so high and low last equally long
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= 1'b0;
    end else if (tick) begin
      q_ff <= ~q_ff;
    end
  end

  assign level = q_ff;
  // Next stage advances only when this one goes high
  assign rise  = tick & ~q_ff;

endmodule // clock_div_stage

// >>> rtl/video_delay_mem.sv
// Circular delay line that fixes the port pipeline latency
`timescale 1ns/1ns
`include "video_oe_map.svh"
module video_delay_mem (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        wrEn,       // One sample per line-locked clock
  input  wire logic [7:0]  wrapPoint,  // Last index, latency minus one
  input  wire logic [15:0] wrData,     // Sample entering the line
  output logic      [15:0] rdData      // Sample leaving, registered
);

  logic [15:0] store [0:`MEM_DEPTH-1]; // Sample storage, no reset
  logic [7:0]  ptr_ff;                 // Shared read/write index
  logic [15:0] rdData_ff;              // Registered read port
  logic [`MEM_DEPTH-1:0] written_ff;   // Entries filled since reset

  // Read old word then overwrite: delay is wrapPoint+1 samples
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      store[ptr_ff] <= wrData;
    end
  end

  // Registered read of the oldest sample
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_ff <= 16'h0000;
    end else if (wrEn) begin
      rdData_ff <= written_ff[ptr_ff] ? store[ptr_ff] : 16'h0000;
    end
  end

  // Words never written read as zero, so the port never shows
  // unknown data after reset or after the latency is lengthened
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      written_ff <= '0;
    end else if (wrEn) begin
      written_ff[ptr_ff] <= 1'b1;
    end
  end

  // Index wraps at the chosen latency
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_ff <= 8'h00;
    end else if (wrEn) begin
      ptr_ff <= (ptr_ff >= wrapPoint) ? 8'h00 : ptr_ff + 8'h01;
    end
  end

  assign rdData = rdData_ff;

  a_ptr_wraps_latency: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (wrEn && ptr_ff == `LATENCY_LINE_CLK - 8'h01 && wrapPoint == ptr_ff)
      |=> (ptr_ff == 8'h00))
    else $error("delay index did not wrap at latency");

endmodule // video_delay_mem

// >>> rtl/video_output_enable_reset_seq.sv
// Output enable, clock family and power-on sequencer of the video port
//
// Operation
// - Upper byte drives only with enable, no fast
// - Lower-byte tristate floats low byte, serial format
// - Produce line clock, half rate, qualifier rates
// - Line clock is four times oscillator rate
// - Every generated clock has even duty
// - Reset on power, enable, lock loss, undervoltage
// - Reset state shown on system reset output
// - After power-on everything floats at least 20 ms
// - Sync sequence enables clocks, control pins, data
// - Port and sync float until host configures
// - Port latency 179 line clocks at zero adjust
// - Serial format copies data onto both bytes
`timescale 1ns/1ns
`include "video_oe_map.svh"
module video_output_enable_reset_seq
  import video_oe_pkg::*;
#(
  parameter int unsigned FLOAT_CYCLES = `FLOAT_CYCLES // Float length
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        chipEnable,
  input  wire logic        pllLock,
  input  wire logic        underVoltage,
  input  wire logic        i2cConfigDone,
  input  wire logic        outputEnableCtl,
  input  wire logic        fastEnableInput,
  input  wire logic        lowerByteTristate,
  input  wire logic [1:0]  outputFormatSelect,
  input  wire logic [1:0]  qualRateSel,
  input  wire logic [2:0]  lumaDelayAdjust,
  input  wire logic [15:0] converterInput,
  input  wire sync_bus_t   syncIn,
  input  wire rt_bus_t     rtIn,
  output port_bus_t        portBus,
  output clk_bus_t         clkBus,
  output sync_bus_t        syncBus,
  output rt_bus_t          rtBus,
  output logic             sdaEnable,
  output logic             sysResetOut_b
);

  localparam logic [`FLOAT_CNT_W-1:0] FLOAT_LAST =
    `FLOAT_CNT_W'(FLOAT_CYCLES - 1);  // Final count of float interval

  seq_state_t               state_ff;        // Sequencer state
  seq_state_t               nxt_state;       // Next sequencer state
  logic [`FLOAT_CNT_W-1:0]  floatCnt_ff;     // Float interval timer
  logic [7:0]               syncCnt_ff;      // Sync sequence timer
  logic                     porReq;          // Any power-on reset cause
  logic                     floatDone;       // Float interval elapsed
  logic                     syncDone;        // Sync sequence elapsed
  logic [`DIV_STAGES-1:0]   divLevel;        // Divider outputs
  logic [`DIV_STAGES-1:0]   divRise;         // Divider rising pulses
  logic [`DIV_STAGES:0]     divTick;         // Divider advance chain
  logic [7:0]               wrapPoint;       // Delay line last index
  logic [15:0]              delayed;         // Sample after latency
  logic                     driveHi;         // Upper byte allowed out
  logic                     floatLo;         // Lower byte held off
  port_bus_t                portBus_ff;      // Registered port
  clk_bus_t                 clkBus_ff;       // Registered clocks
  sync_bus_t                syncBus_ff;      // Registered sync pins
  rt_bus_t                  rtBus_ff;        // Registered control pins
  logic                     sdaEnable_ff;    // Data line permission
  logic                     sysResetOut_b_ff;// Reset seen by system

  // Any cause forces the float state at once
  assign porReq    = ~chipEnable | ~pllLock | underVoltage;
  assign floatDone = (floatCnt_ff == FLOAT_LAST);
  assign syncDone  = (syncCnt_ff == `SYNC_CYCLES - 8'h01);

  // Float timer runs on the reference crystal, only while locked
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      floatCnt_ff <= '0;
    end else if (porReq || state_ff != ST_FLOAT) begin
      floatCnt_ff <= '0;
    end else if (!floatDone) begin
      floatCnt_ff <= floatCnt_ff + `FLOAT_CNT_W'(1);
    end
  end

  // Sync sequence timer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncCnt_ff <= 8'h00;
    end else if (state_ff != ST_SYNC || porReq) begin
      syncCnt_ff <= 8'h00;
    end else if (!syncDone) begin
      syncCnt_ff <= syncCnt_ff + 8'h01;
    end
  end

  // Sequencer next state; a reset cause always wins
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // Release only once locked long enough
      ST_FLOAT: begin
        if (floatDone && pllLock) begin
          nxt_state = ST_SYNC;
        end
      end
      // Clocks running, port still floating
      ST_SYNC: begin
        if (syncDone) begin
          nxt_state = ST_READY;
        end
      end
      // Wait for host configuration
      ST_READY: begin
        if (i2cConfigDone) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        nxt_state = ST_ACTIVE;
      end
      default: begin
        nxt_state = ST_FLOAT;
      end
    endcase
    if (porReq) begin
      nxt_state = ST_FLOAT;
    end
  end

  // Sequencer state register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_FLOAT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Divider chain: line clock toggles every reference cycle, each
  // further stage halves it. Stage 2 runs at the oscillator rate.
  assign divTick[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 0; gi < `DIV_STAGES; gi++) begin : g_div
      clock_div_stage u_stage (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .tick    (divTick[gi]),
        .level   (divLevel[gi]),
        .rise    (divRise[gi])
      );
      assign divTick[gi+1] = divRise[gi];
    end
  endgenerate

  // Clock pins; qualifier copies one divided rate so duty stays even
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkBus_ff <= '0;
    end else begin
      clkBus_ff.lineClk    <= divLevel[0];
      clkBus_ff.halfClk    <= divLevel[1];
      clkBus_ff.quarterClk <= divLevel[2];
      clkBus_ff.eighthClk  <= divLevel[3];
      case (qualRateSel)
        `QUAL_QUARTER: clkBus_ff.clkQual <= divLevel[2];
        `QUAL_EIGHTH:  clkBus_ff.clkQual <= divLevel[3];
        default:       clkBus_ff.clkQual <= divLevel[1];
      endcase
      clkBus_ff.oe <= (state_ff != ST_FLOAT);
    end
  end

  // Control, status and switch pins live from the sync sequence on
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rtBus_ff     <= '0;
      sdaEnable_ff <= 1'b0;
    end else begin
      rtBus_ff.ctlOut    <= rtIn.ctlOut;
      rtBus_ff.status0   <= rtIn.status0;
      rtBus_ff.status1   <= rtIn.status1;
      rtBus_ff.switchOut <= rtIn.switchOut;
      rtBus_ff.oe   <= (state_ff != ST_FLOAT);
      sdaEnable_ff  <= (state_ff != ST_FLOAT);
    end
  end

  // Reference and sync pins wait for the host configuration
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncBus_ff <= '0;
    end else begin
      syncBus_ff.horizRef  <= syncIn.horizRef;
      syncBus_ff.horizSync <= syncIn.horizSync;
      syncBus_ff.vertSync  <= syncIn.vertSync;
      syncBus_ff.oe   <= (state_ff == ST_ACTIVE);
    end
  end

  // System reset held low until the sequence has finished
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sysResetOut_b_ff <= 1'b0;
    end else begin
      sysResetOut_b_ff <= (state_ff == ST_READY) ||
                          (state_ff == ST_ACTIVE);
    end
  end

  // Latency fixed by delay line; adjust lengthens it. Changing the
  // adjust mid-stream disturbs a few samples, so set it while idle.
  assign wrapPoint = `LATENCY_LINE_CLK - 8'h01 + {5'h00, lumaDelayAdjust};

  video_delay_mem u_delay (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .wrEn      (divRise[0]),
    .wrapPoint (wrapPoint),
    .wrData    (converterInput),
    .rdData    (delayed)
  );

  // Enable gating: upper byte needs enable set and fast input clear
  assign driveHi = (state_ff == ST_ACTIVE) && outputEnableCtl &&
                   !fastEnableInput;
  // Tristate bit counts only in the serial format
  assign floatLo = (outputFormatSelect == `FMT_SERIAL8) &&
                   lowerByteTristate;

  // Port data and enables
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      portBus_ff <= '0;
    end else begin
      portBus_ff.hiData <= delayed[15:8];
      if (outputFormatSelect == `FMT_SERIAL8) begin
        portBus_ff.loData <= delayed[15:8];
      end else begin
        portBus_ff.loData <= delayed[7:0];
      end
      portBus_ff.hiOe <= driveHi;
      portBus_ff.loOe <= driveHi && !floatLo;
    end
  end

  assign portBus       = portBus_ff;
  assign clkBus        = clkBus_ff;
  assign syncBus       = syncBus_ff;
  assign rtBus         = rtBus_ff;
  assign sdaEnable     = sdaEnable_ff;
  assign sysResetOut_b = sysResetOut_b_ff;

  a_upper_byte_gate: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!outputEnableCtl || fastEnableInput)
      |=> (!portBus.hiOe && !portBus.loOe))
    else $error("port driven without enable");

  a_lower_byte_float: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (state_ff == ST_ACTIVE && outputEnableCtl && !fastEnableInput &&
     outputFormatSelect == `FMT_SERIAL8 && lowerByteTristate)
      |=> (portBus.hiOe && !portBus.loOe))
    else $error("lower byte not floated");

  a_half_clock_step: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $changed(clkBus.halfClk) |-> $rose(clkBus.lineClk))
    else $error("half clock off line clock edge");

  a_osc_ratio_four: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(clkBus.quarterClk) |-> ##8 $rose(clkBus.quarterClk))
    else $error("oscillator rate not quarter line clock");

  a_even_duty: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(clkBus.halfClk) |-> clkBus.halfClk ##1 clkBus.halfClk
      ##1 !clkBus.halfClk ##1 !clkBus.halfClk ##1 clkBus.halfClk)
    else $error("half clock duty not even");

  a_reset_causes: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    porReq |=> (state_ff == ST_FLOAT) ##1 !sysResetOut_b)
    else $error("reset cause did not restart sequence");

  a_reset_output: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(sysResetOut_b) |-> ($past(state_ff) == ST_READY))
    else $error("reset released outside sequence end");

  a_float_all_pins: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (state_ff == ST_FLOAT) |=> (!clkBus.oe && !rtBus.oe && !sdaEnable &&
                               !syncBus.oe && !portBus.hiOe))
    else $error("pin driven during float");

  a_sync_enables: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (state_ff == ST_SYNC) |=> (clkBus.oe && rtBus.oe && sdaEnable &&
                              !syncBus.oe && !portBus.hiOe))
    else $error("wrong enables during sync sequence");

  a_config_gate: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (state_ff != ST_ACTIVE) |=> (!syncBus.oe && !portBus.loOe))
    else $error("port live before configuration");

  a_serial_copy: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (outputFormatSelect == `FMT_SERIAL8 && !lowerByteTristate)
      |=> (portBus.loData == portBus.hiData))
    else $error("serial data not on both bytes");

  a_lock_release: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (state_ff == ST_FLOAT && nxt_state == ST_SYNC)
      |-> (floatCnt_ff == FLOAT_LAST && pllLock))
    else $error("sequence released early or unlocked");

endmodule // video_output_enable_reset_seq

// >>> sim/host_config_model.sv
// Downstream host model: configures the device after its reset output
`timescale 1ns/1ns
module host_config_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       sysResetOut_b,
  input  wire logic [7:0] cfgDelay,     // Slow or prompt host, cycles
  output logic            i2cConfigDone
);
  logic [7:0] waitCnt_ff;    // Cycles since device left reset
  logic       cfgDone_ff;    // One-cycle end of full configuration

  // Host holds off while the device is in reset, then sends once
  always_ff @(negedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_ff <= 8'h00;
      cfgDone_ff <= 1'b0;
    end else if (!sysResetOut_b) begin
      waitCnt_ff <= 8'h00;
      cfgDone_ff <= 1'b0;
    end else if (waitCnt_ff <= cfgDelay) begin
      // Pulse once; the counter parks so there is no second send
      waitCnt_ff <= waitCnt_ff + 8'h01;
      cfgDone_ff <= (waitCnt_ff == cfgDelay);
    end else begin
      cfgDone_ff <= 1'b0;
    end
  end

  assign i2cConfigDone = cfgDone_ff;
endmodule // host_config_model

// >>> sim/video_output_enable_reset_seq_tb.sv
// Self-checking bench for the video output enable sequencer
`timescale 1ns/1ns
module video_output_enable_reset_seq_tb;
  import video_oe_pkg::*;
  localparam int unsigned FC = 10; // Short float interval for sim

  logic        ref_clk, rst_b, chipEnable, pllLock, underVoltage, cfgDone;
  logic        oeCtl, fastEn, loTri;
  logic [1:0]  fmt, qualSel;
  logic [2:0]  lumaAdj;
  logic [15:0] convIn;
  logic [7:0]  cfgDelay;
  port_bus_t   portBus;
  clk_bus_t    clkBus;
  sync_bus_t   syncBus;
  rt_bus_t     rtBus;
  logic        sdaEnable, sysResetOut_b;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          rc[5], hc[5], n;

  video_output_enable_reset_seq #(.FLOAT_CYCLES(FC))
    i_video_output_enable_reset_seq (
    .ref_clk(ref_clk), .rst_b(rst_b), .chipEnable(chipEnable),
    .pllLock(pllLock), .underVoltage(underVoltage),
    .i2cConfigDone(cfgDone), .outputEnableCtl(oeCtl),
    .fastEnableInput(fastEn), .lowerByteTristate(loTri),
    .outputFormatSelect(fmt), .qualRateSel(qualSel),
    .lumaDelayAdjust(lumaAdj), .converterInput(convIn),
    .syncIn(4'b1010), .rtIn(5'b10110), .portBus(portBus), .clkBus(clkBus),
    .syncBus(syncBus), .rtBus(rtBus), .sdaEnable(sdaEnable),
    .sysResetOut_b(sysResetOut_b));

  host_config_model i_host_config_model (
    .ref_clk(ref_clk), .rst_b(rst_b), .sysResetOut_b(sysResetOut_b),
    .cfgDelay(cfgDelay), .i2cConfigDone(cfgDone));

  // 50 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Verdict and end of run, also reached on a hang
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp,
                         input string s);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  // Bench-side counts checked against an inclusive window
  task automatic cmp_range(input int got, input int lo, input int hi,
                           input string s);
    cmp_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] %0t %s count %0d not %0d..%0d", $time, s, got, lo, hi);
    end
  endtask

  task automatic hang(input string s);
    miscompares++;
    $display("[ERR] %0t timeout waiting for %s", $time, s);
    tally_and_finish();
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // 0 clock enable, 1 reset output, 2 sync enable
  function automatic logic sel_sig(input int s);
    case (s)
      0: return clkBus.oe;
      1: return sysResetOut_b;
      default: return syncBus.oe;
    endcase
  endfunction

  // Bounded wait, counts falling edges until the signal is high
  task automatic wait_high(input int s, input int lim, output int k);
    k = 0;
    while (sel_sig(s) !== 1'b1) begin
      @(negedge ref_clk);
      k++;
      if (k > lim) hang("enable");
    end
  endtask

  task automatic t_powerup();
    rst_b = 1'b0;
    cycles(6);
    cmp_bit(clkBus.oe, 1'b0, "clk oe in reset");
    cmp_bit(sysResetOut_b, 1'b0, "reset out");
    rst_b = 1'b1;
    cycles(2);
    cmp_bit(portBus.hiOe | portBus.loOe | clkBus.oe | syncBus.oe | rtBus.oe
            | sdaEnable, 1'b0, "float");
    wait_high(0, FC + 10, n);
    cmp_range(n + 2, FC, FC + 2, "float length");
    cmp_bit(rtBus.oe & sdaEnable, 1'b1, "sync enables");
    // Pin levels pass through: sync 101, control 1011
    cmp_val({9'h000, syncBus[3:1], rtBus[4:1]}, 16'h005b, "pins");
    cmp_bit(syncBus.oe | portBus.hiOe, 1'b0, "port in sync");
    wait_high(1, 40, n);
    cmp_range(n, 31, 33, "sync length");
    // Slow host: port must stay off until configured
    cmp_bit(syncBus.oe | portBus.hiOe, 1'b0, "port before cfg");
    wait_high(2, 40, n);
    cmp_range(n, 20, 25, "cfg wait");
    cmp_bit(portBus.hiOe, 1'b1, "port after cfg");
    $display("test powerup done");
  endtask

  // All enable, fast and tristate combinations, in format 0 and the serial format
  task automatic t_enable_table();
    logic hi;
    for (int i = 0; i < 16; i++) begin
      oeCtl = i[0];
      fastEn = i[1];
      loTri = i[2];
      fmt = i[3] ? 2'h3 : 2'h0;
      cycles(2);
      hi = i[0] & !i[1];
      cmp_bit(portBus.hiOe, hi, "upper oe");
      cmp_bit(portBus.loOe, hi & !(i[3] & i[2]), "lower oe");
    end
    {oeCtl, fastEn, loTri, fmt} = 5'b10000;
    $display("test enable table done");
  endtask

  // Rises and high samples of each clock over 64 reference cycles
  task automatic count_rises();
    clk_bus_t p;
    p = clkBus;
    rc = '{default: 0};
    hc = '{default: 0};
    repeat (64) begin
      @(negedge ref_clk);
      for (int k = 0; k < 5; k++) begin
        if (clkBus[5-k] && !p[5-k]) rc[k]++;
        if (clkBus[5-k]) hc[k]++;
      end
      p = clkBus;
    end
  endtask

  task automatic t_clocks();
    int e;
    for (int s = 0; s < 4; s++) begin
      qualSel = s[1:0];
      cycles(4);
      count_rises();
      for (int k = 0; k < 4; k++) begin
        cmp_range(rc[k], 32 >> k, 32 >> k, "clock rate");
        cmp_range(hc[k], 32, 32, "clock duty");
      end
      e = (s == 1) ? 8 : (s == 2) ? 4 : 16;
      cmp_range(rc[4], e, e, "qualifier rate");
    end
    $display("test clocks done");
  endtask

  // Step the converter input and time its arrival on the port
  task automatic lat_step(input logic [2:0] adj, input logic [15:0] v);
    lumaAdj = adj;
    convIn = ~v;
    cycles(420);
    convIn = v;
    n = 0;
    while (portBus.hiData !== v[15:8]) begin
      @(negedge ref_clk);
      n++;
      if (n > 500) hang("port data");
    end
    cmp_range(n, 2 * (179 + adj), 2 * (179 + adj) + 3, "latency");
    cmp_val({8'h00, portBus.loData},
            {8'h00, (fmt == 2'h3) ? v[15:8] : v[7:0]}, "low byte");
  endtask

  task automatic t_latency();
    fmt = 2'h0;
    lat_step(3'h0, 16'hab5c);
    fmt = 2'h3;
    lat_step(3'h2, 16'h6e21);
    fmt = 2'h0;
    $display("test latency done");
  endtask

  // Each internal reset cause, held well past the float interval
  task automatic t_causes();
    for (int c = 0; c < 3; c++) begin
      chipEnable = (c != 0);
      pllLock = (c != 1);
      underVoltage = (c == 2);
      cycles(3);
      cmp_bit(clkBus.oe | portBus.hiOe, 1'b0, "cause floats");
      cmp_bit(sysResetOut_b, 1'b0, "cause reset out");
      cycles(FC + 40);
      cmp_bit(clkBus.oe, 1'b0, "held cause");
      {chipEnable, pllLock, underVoltage} = 3'b110;
      cfgDelay = 8'h00;
      wait_high(1, FC + 60, n);
      wait_high(2, 10, n);
      cmp_bit(portBus.hiOe, 1'b1, "port back");
    end
    $display("test causes done");
  endtask

  // Main sequence, inputs valued at time zero
  initial begin
    {rst_b, chipEnable, pllLock, underVoltage} = 4'b0110;
    {oeCtl, fastEn, loTri, fmt, qualSel} = 7'b1000000;
    lumaAdj = 3'h0;
    convIn = 16'h0000;
    cfgDelay = 8'h14;
    @(negedge ref_clk);
    t_powerup();
    t_enable_table();
    t_clocks();
    t_latency();
    t_causes();
    tally_and_finish();
  end
endmodule // video_output_enable_reset_seq_tb
